/* ecl_defines.svh */
`ifndef ECL_DEFINES_SVH
`define ECL_DEFINES_SVH

// Capability window, dword index of a byte address within the capability
`define ECL_DW_CAP    6'h02
`define ECL_DW_DATA   6'h03
`define ECL_LANE_ADDR 2
`define ECL_FLAG_BIT  7
`define ECL_CAP_ID    8'h03
`define ECL_NEXT_PTR  8'h00
`define ECL_ADDR_RST  7'h00
`define ECL_DATA_RST  32'h0000_0000

// Serial link
`define ECL_SLAVE     7'h50
`define ECL_LAST_TB   3'h6
`define ECL_LAST_WTB  3'h5
`define ECL_LOAD_WDS  2'h2

// Timing
`define ECL_CLK_NS    50
`define ECL_SCL_NS    400
`define ECL_SCL_QCYC  ((`ECL_SCL_NS) / (4 * `ECL_CLK_NS))
`define ECL_T_WR_US   5000
`define ECL_T_WR_CYC  ((`ECL_T_WR_US * 1000 + `ECL_CLK_NS - 1) / `ECL_CLK_NS)

`endif

/* ecl_pkg.sv */
package ecl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_TX    = 3'h3,
    ST_RX    = 3'h2,
    ST_STOP  = 3'h6,
    ST_WWAIT = 3'h7
  } ecl_state_e;

  typedef enum logic [1:0] {
    BC_START = 2'h0,
    BC_WR    = 2'h1,
    BC_RD    = 2'h3,
    BC_STOP  = 2'h2
  } ecl_bcmd_e;

  typedef enum logic [1:0] {
    OP_LOAD  = 2'h0,
    OP_READ  = 2'h1,
    OP_WRITE = 2'h2
  } ecl_op_e;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } ecl_sync_s;

  typedef struct packed {
    logic       busy;
    ecl_bcmd_e  cmd;
    logic       din;
    logic [1:0] q;
    logic [3:0] cnt;
    logic       scl_oe;
    logic       sda_oe;
    logic       dout;
    logic       done;
  } ecl_bit_s;

  typedef struct packed {
    ecl_state_e  st;
    ecl_op_e     op;
    logic [2:0]  tb;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        fail;
    logic        req;
    ecl_bcmd_e   bc;
    logic        bdin;
    logic [1:0]  lw;
    logic [16:0] wcnt;
    logic [6:0]  addr;
    logic        flag;
    logic        pend;
    logic [31:0] data;
    logic [31:0] rdata;
    logic [63:0] ids;
    logic [31:0] opt;
    logic        loaded;
    logic        present;
  } ecl_main_s;

endpackage

/* ecl_sync2.sv */
module ecl_sync2 import ecl_pkg::*; (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic [1:0] din,
  output logic      [1:0] dout
);
  ecl_sync_s s_r;
  ecl_sync_s s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
  end

  // Released lines idle high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '{s1: 2'h3, s2: 2'h3};
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.s2;
endmodule // ecl_sync2

/* ecl_i2c_bit.sv */
`include "ecl_defines.svh"
module ecl_i2c_bit import ecl_pkg::*; (
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      clk_en,
  input  wire logic      req,
  input  wire ecl_bcmd_e cmd,
  input  wire logic      din,
  input  wire logic      scl_s,
  input  wire logic      sda_s,
  output logic           done,
  output logic           dout,
  output logic           scl_oe,
  output logic           sda_oe
);
  localparam logic [3:0] QC = 4'(`ECL_SCL_QCYC - 1);

  ecl_bit_s s_r;
  ecl_bit_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy) begin
      // Done flop blocks a stale request in the hand-off cycle
      if (req && !s_r.done) begin
        s_nxt.busy = 1'b1;
        s_nxt.cmd  = cmd;
        s_nxt.din  = din;
        s_nxt.q    = 2'h0;
        s_nxt.cnt  = QC;
        unique case (cmd)
          BC_START: s_nxt.sda_oe = 1'b0;
          BC_STOP:  s_nxt.sda_oe = 1'b1;
          BC_WR:    s_nxt.sda_oe = ~din;
          BC_RD:    s_nxt.sda_oe = 1'b0;
        endcase
      end
    end else if (s_r.cnt != 4'h0) begin
      s_nxt.cnt = s_r.cnt - 4'h1;
    end else begin
      s_nxt.cnt = QC;
      unique case (s_r.q)
        2'h0: begin
          s_nxt.q      = 2'h1;
          s_nxt.scl_oe = 1'b0;
        end
        2'h1: begin
          // Slave may stretch the clock; start also needs a free bus
          if (!scl_s || (s_r.cmd == BC_START && !sda_s)) begin
            s_nxt.cnt = 4'h0;
          end else begin
            s_nxt.q = 2'h2;
            if (s_r.cmd == BC_START) begin
              s_nxt.sda_oe = 1'b1;
            end
            if (s_r.cmd == BC_STOP) begin
              s_nxt.sda_oe = 1'b0;
            end
            if (s_r.cmd == BC_RD) begin
              s_nxt.dout = sda_s;
            end
          end
        end
        2'h2: begin
          s_nxt.q = 2'h3;
          if (s_r.cmd != BC_STOP) begin
            s_nxt.scl_oe = 1'b1;
          end
        end
        2'h3: begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign done   = s_r.done;
  assign dout   = s_r.dout;
  assign scl_oe = s_r.scl_oe;
  assign sda_oe = s_r.sda_oe;
endmodule // ecl_i2c_bit

/* ecl_config_loader.sv */
`include "ecl_defines.svh"
module ecl_config_loader import ecl_pkg::*; #(
  // Arbitrary values, not tied to any maker
  parameter logic [15:0] DEF_VENDOR_ID  = 16'h1234,
  parameter logic [15:0] DEF_DEVICE_ID  = 16'h5678,
  parameter logic [15:0] DEF_SUB_VENDOR = 16'h9ABC,
  parameter logic [15:0] DEF_SUB_DEVICE = 16'hDEF0,
  parameter int          WRITE_WAIT_CYC = `ECL_T_WR_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic      [15:0] vendor_id,
  output logic      [15:0] device_id,
  output logic      [15:0] subsys_vendor_id,
  output logic      [15:0] subsys_device_id,
  output logic      [31:0] option_bits,
  output logic             load_done,
  output logic             eeprom_present
);
  localparam logic [63:0] DEF_IDS = {DEF_SUB_DEVICE, DEF_SUB_VENDOR,
                                     DEF_DEVICE_ID, DEF_VENDOR_ID};

  ecl_main_s s_r;
  ecl_main_s s_nxt;

  logic [1:0] lines_s;
  logic       bdone;
  logic       bdout;
  logic [6:0] ea;

  ecl_sync2 u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .din     ({scl_i, sda_i}),
    .dout    (lines_s)
  );

  ecl_i2c_bit u_bit (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .req     (s_r.req),
    .cmd     (s_r.bc),
    .din     (s_r.bdin),
    .scl_s   (lines_s[1]),
    .sda_s   (lines_s[0]),
    .done    (bdone),
    .dout    (bdout),
    .scl_oe  (scl_oe),
    .sda_oe  (sda_oe)
  );

  // Open-drain: only the enables ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  function automatic logic [7:0] tx_byte(
    input logic [2:0]  tb,
    input logic        wr,
    input logic [6:0]  a,
    input logic [31:0] d
  );
    logic [7:0] b;
    b = 8'h00;
    if (tb == 3'h0) begin
      b = {`ECL_SLAVE, 1'b0};
    end else if (tb == 3'h1) begin
      b = {1'b0, a};
    end else if (!wr) begin
      b = {`ECL_SLAVE, 1'b1};
    end else begin
      b = 8'(d >> {tb - 3'h2, 3'h0});
    end
    return b;
  endfunction

  function automatic logic [31:0] reg_read(
    input logic [7:0]  a,
    input ecl_main_s   s
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a[7:2] == `ECL_DW_CAP) begin
      r = {8'h00, s.flag, s.addr, `ECL_NEXT_PTR, `ECL_CAP_ID};
    end else if (a[7:2] == `ECL_DW_DATA) begin
      r = s.data;
    end
    return r;
  endfunction

  // Load words sit at 0, 4, 8; host words at the programmed address
  assign ea = (s_r.op == OP_LOAD) ? {3'h0, s_r.lw, 2'h0} : s_r.addr;

  always_comb begin
    s_nxt = s_r;

    if (cfg_rd) begin
      s_nxt.rdata = reg_read(cfg_addr, s_r);
    end

    // Writes while a host request is pending are dropped to keep the word coherent
    if (cfg_wr && !s_r.pend) begin
      if (cfg_addr[7:2] == `ECL_DW_CAP && cfg_be[`ECL_LANE_ADDR]) begin
        s_nxt.addr = {cfg_wdata[22:18], 2'h0};
        s_nxt.flag = cfg_wdata[16 + `ECL_FLAG_BIT];
        s_nxt.pend = 1'b1;
      end
      if (cfg_addr[7:2] == `ECL_DW_DATA) begin
        for (int i = 0; i < 4; i++) begin
          if (cfg_be[i]) begin
            s_nxt.data[8*i +: 8] = cfg_wdata[8*i +: 8];
          end
        end
      end
    end

    if (s_r.st == ST_IDLE && (s_r.pend || !s_r.loaded)) begin
      s_nxt.st   = ST_START;
      s_nxt.tb   = 3'h0;
      s_nxt.fail = 1'b0;
      s_nxt.req  = 1'b1;
      s_nxt.bc   = BC_START;
      if (!s_r.loaded) begin
        s_nxt.op = OP_LOAD;
      end else if (s_r.flag) begin
        s_nxt.op = OP_WRITE;
      end else begin
        s_nxt.op = OP_READ;
      end
    end

    if (s_r.st == ST_WWAIT) begin
      // Fixed write-cycle wait instead of acknowledge polling
      if (s_r.wcnt == 17'(WRITE_WAIT_CYC - 1)) begin
        s_nxt.st   = ST_IDLE;
        s_nxt.flag = 1'b0;
        s_nxt.pend = 1'b0;
      end else begin
        s_nxt.wcnt = s_r.wcnt + 17'h1;
      end
    end

    if (bdone) begin
      s_nxt.req = 1'b0;
      unique case (s_r.st)
        ST_START: begin
          s_nxt.st   = ST_TX;
          s_nxt.bitn = 4'h0;
          s_nxt.sh   = tx_byte(s_r.tb, s_r.op == OP_WRITE, ea, s_r.data);
          s_nxt.req  = 1'b1;
          s_nxt.bc   = BC_WR;
          s_nxt.bdin = s_nxt.sh[7];
        end
        ST_TX: begin
          s_nxt.req = 1'b1;
          if (s_r.bitn < 4'h7) begin
            s_nxt.bitn = s_r.bitn + 4'h1;
            s_nxt.sh   = {s_r.sh[6:0], 1'b0};
            s_nxt.bc   = BC_WR;
            s_nxt.bdin = s_r.sh[6];
          end else if (s_r.bitn == 4'h7) begin
            s_nxt.bitn = 4'h8;
            s_nxt.bc   = BC_RD;
          end else if (bdout) begin
            // No acknowledge: end the transfer cleanly
            s_nxt.fail = 1'b1;
            s_nxt.st   = ST_STOP;
            s_nxt.bc   = BC_STOP;
          end else if (s_r.op != OP_WRITE && s_r.tb == 3'h1) begin
            s_nxt.tb = 3'h2;
            s_nxt.st = ST_START;
            s_nxt.bc = BC_START;
          end else if (s_r.op != OP_WRITE && s_r.tb == 3'h2) begin
            s_nxt.tb   = 3'h3;
            s_nxt.st   = ST_RX;
            s_nxt.bitn = 4'h0;
            s_nxt.bc   = BC_RD;
          end else if (s_r.op == OP_WRITE && s_r.tb == `ECL_LAST_WTB) begin
            s_nxt.st = ST_STOP;
            s_nxt.bc = BC_STOP;
          end else begin
            s_nxt.tb   = s_r.tb + 3'h1;
            s_nxt.bitn = 4'h0;
            s_nxt.sh   = tx_byte(s_nxt.tb, s_r.op == OP_WRITE, ea, s_r.data);
            s_nxt.bc   = BC_WR;
            s_nxt.bdin = s_nxt.sh[7];
          end
        end
        ST_RX: begin
          s_nxt.req = 1'b1;
          if (s_r.bitn < 4'h8) begin
            s_nxt.sh   = {s_r.sh[6:0], bdout};
            s_nxt.bitn = s_r.bitn + 4'h1;
            s_nxt.bc   = BC_RD;
            if (s_r.bitn == 4'h7) begin
              // Acknowledge all but the last byte
              s_nxt.bc   = BC_WR;
              s_nxt.bdin = (s_r.tb == `ECL_LAST_TB);
            end
          end else begin
            s_nxt.data = {s_r.sh, s_r.data[31:8]};
            if (s_r.tb == `ECL_LAST_TB) begin
              s_nxt.st = ST_STOP;
              s_nxt.bc = BC_STOP;
            end else begin
              s_nxt.tb   = s_r.tb + 3'h1;
              s_nxt.bitn = 4'h0;
              s_nxt.bc   = BC_RD;
            end
          end
        end
        ST_STOP: begin
          s_nxt.st = ST_IDLE;
          unique case (s_r.op)
            OP_LOAD: begin
              if (s_r.fail) begin
                s_nxt.ids     = DEF_IDS;
                s_nxt.opt     = 32'h0000_0000;
                s_nxt.present = 1'b0;
                s_nxt.loaded  = 1'b1;
                s_nxt.data    = `ECL_DATA_RST;
              end else begin
                s_nxt.present = 1'b1;
                s_nxt.lw      = s_r.lw + 2'h1;
                if (s_r.lw == 2'h0) begin
                  s_nxt.ids[31:0] = s_r.data;
                end
                if (s_r.lw == 2'h1) begin
                  s_nxt.ids[63:32] = s_r.data;
                end
                if (s_r.lw == `ECL_LOAD_WDS) begin
                  s_nxt.opt    = s_r.data;
                  s_nxt.loaded = 1'b1;
                  s_nxt.data   = `ECL_DATA_RST;
                end
              end
            end
            OP_READ: begin
              s_nxt.flag = 1'b1;
              s_nxt.pend = 1'b0;
            end
            OP_WRITE: begin
              if (s_r.fail) begin
                s_nxt.flag = 1'b0;
                s_nxt.pend = 1'b0;
              end else begin
                s_nxt.st   = ST_WWAIT;
                s_nxt.wcnt = 17'h0;
              end
            end
            default: begin
              s_nxt.pend = 1'b0;
            end
          endcase
        end
        default: begin
          s_nxt.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r         <= '0;
      s_r.st      <= ST_IDLE;
      s_r.op      <= OP_LOAD;
      s_r.bc      <= BC_START;
      s_r.addr    <= `ECL_ADDR_RST;
      s_r.data    <= `ECL_DATA_RST;
      s_r.ids     <= DEF_IDS;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign cfg_rdata        = s_r.rdata;
  assign vendor_id        = s_r.ids[15:0];
  assign device_id        = s_r.ids[31:16];
  assign subsys_vendor_id = s_r.ids[47:32];
  assign subsys_device_id = s_r.ids[63:48];
  assign option_bits      = s_r.opt;
  assign load_done        = s_r.loaded;
  assign eeprom_present   = s_r.present;
endmodule // ecl_config_loader

/* ecl_config_loader_monitor.sv */
module ecl_config_loader_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic [7:0]  cfg_addr,
  input wire logic        cfg_rd,
  input wire logic [31:0] cfg_rdata,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        scl_o,
  input wire logic        sda_o,
  input wire logic [15:0] vendor_id,
  input wire logic [31:0] option_bits,
  input wire logic        load_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_reset_values: assert property (
    $fell(sys_rst) |-> !scl_oe && !sda_oe && cfg_rdata == 32'h0 && !load_done)
    else $error("outputs not at reset values");
  a_cap_word: assert property (
    cfg_rd && clk_en && cfg_addr[7:2] == 6'h02 |=>
      cfg_rdata[15:0] == 16'h0003 && cfg_rdata[17:16] == 2'h0 && cfg_rdata[31:24] == 8'h00)
    else $error("capability word wrong");
  a_rdata_holds: assert property (
    !$past(cfg_rd) && !$past(sys_rst) |-> $stable(cfg_rdata))
    else $error("read data moved without a read");
  a_start_bus_free: assert property (
    $rose(sda_oe) && !scl_oe |-> $past(scl_i) && $past(sda_i))
    else $error("start while bus busy");
  a_start_clocks: assert property (
    $rose(sda_oe) && !scl_oe |-> ##[1:16] scl_oe)
    else $error("no clock after start");
  a_stop_idle: assert property (
    $fell(sda_oe) && !scl_oe |-> (!sda_oe && !scl_oe) [*3])
    else $error("bus not idle after stop");
  a_low_phase: assert property (
    $rose(scl_oe) |-> scl_oe [*3])
    else $error("clock low phase short");
  a_high_phase: assert property (
    $fell(scl_oe) |-> !scl_oe [*3])
    else $error("clock high phase short");
  a_open_drain: assert property (
    !scl_o && !sda_o)
    else $error("line driven high");
  a_load_released: assert property (
    $rose(load_done) |-> !scl_oe && !sda_oe)
    else $error("lines held after load");
  a_ids_frozen: assert property (
    load_done |=> load_done && $stable(vendor_id) && $stable(option_bits))
    else $error("identifiers moved after load");
endmodule // ecl_config_loader_monitor

bind ecl_config_loader ecl_config_loader_monitor u_ecl_config_loader_monitor (
  .clk, .sys_rst, .clk_en, .cfg_addr, .cfg_rd, .cfg_rdata, .scl_i, .sda_i,
  .scl_oe, .sda_oe, .scl_o, .sda_o, .vendor_id, .option_bits, .load_done
);

/* ecl_eeprom_model.sv */
module ecl_eeprom_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic present,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [128];
  logic [7:0] sh;
  logic [6:0] ptr;
  logic       go;
  logic       rd;
  int         n;
  int         k;

  initial begin
    sda_oe = 1'b0;
    go = 1'b0;
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 3 + 1);
  end
  always @(negedge sda) if (scl) begin
    go = present;
    n = 0;
    k = 0;
  end
  always @(posedge sda) if (scl) go = 1'b0;
  always @(posedge scl) if (go) begin
    if (n < 8) sh = {sh[6:0], sda};
    else if (rd && sda) go = 1'b0;
    n++;
  end
  // Changes only on falling clock, so data is steady while high
  always @(negedge scl) if (go) begin
    if (n == 8) begin
      if (k == 0) begin
        rd = sh[0];
        go = (sh[7:1] == 7'h50);
      end else if (!rd && k == 1) ptr = sh[6:0];
      else if (!rd) begin
        mem[ptr] = sh;
        ptr++;
      end else ptr++;
      sda_oe = go && !(rd && k > 0);
      k++;
    end else begin
      if (n == 9) n = 0;
      sda_oe = rd && k > 0 && !mem[ptr][7 - n];
    end
  end
endmodule // ecl_eeprom_model

/* tb_ecl_config_loader.sv */
module tb_ecl_config_loader;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        sys_rst;
  logic        clk_en;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        scl_oe;
  logic        sda_oe;
  logic        m_oe;
  logic        present;
  logic [15:0] vendor_id;
  logic [15:0] device_id;
  logic [15:0] subsys_vendor_id;
  logic [15:0] subsys_device_id;
  logic [31:0] option_bits;
  logic        load_done;
  logic        eeprom_present;
  logic        scl;
  logic        sda;
  logic [7:0]  img [128];
  logic [31:0] q;
  logic [6:0]  ra [3] = '{7'h13, 7'h7C, 7'h00};
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;

  // Pull-ups: a released line reads high
  assign scl = !scl_oe;
  assign sda = !(sda_oe || m_oe);

  ecl_config_loader #(.WRITE_WAIT_CYC(20)) u_ecl_config_loader (
    .clk, .sys_rst, .clk_en, .cfg_addr, .cfg_be, .cfg_wr, .cfg_rd, .cfg_wdata,
    .cfg_rdata, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe,
    .vendor_id, .device_id, .subsys_vendor_id, .subsys_device_id, .option_bits,
    .load_done, .eeprom_present
  );
  ecl_eeprom_model u_ecl_eeprom_model (.scl, .sda, .present, .sda_oe(m_oe));

  always #25 clk = ~clk;

  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] be);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_be <= be;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] r);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    @(posedge clk);
    r = cfg_rdata;
  endtask

  task automatic start(logic [6:0] a, logic f);
    wr(8'h08, {8'h00, f, a, 16'h0000}, 4'h4);
  endtask

  // Bounded poll; a hang shows up as a flag mismatch
  task automatic wait_flag(logic want, output logic [31:0] r);
    for (int i = 0; i < 2000; i++) begin
      rd(8'h08, r);
      if (r[23] === want) break;
    end
    chk("flag", r[23], want);
  endtask

  task automatic boot(logic p);
    present <= p;
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("reset data", cfg_rdata, 0);
    for (int i = 0; i < 6000 && !load_done; i++) @(posedge clk);
  endtask

  function automatic logic [31:0] w(int a);
    return {img[a + 3], img[a + 2], img[a + 1], img[a]};
  endfunction

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = 32'h0;
    present = 1'b0;
    for (int i = 0; i < 128; i++) img[i] = 8'(i * 3 + 1);
    boot(1'b0);
    chk("present", eeprom_present, 0);
    chk("ids", {vendor_id, device_id, subsys_vendor_id, subsys_device_id}, 64'h1234_5678_9ABC_DEF0);
    chk("options", option_bits, 0);
    rd(8'h08, q);
    chk("cap word", q, 32'h0000_0003);
    wr(8'h0C, 32'h1357_9BDF, 4'hF);
    start(7'h04, 1'b0);
    wait_flag(1'b1, q);
    rd(8'h0C, q);
    chk("nack data", q, 32'h1357_9BDF);
    boot(1'b1);
    chk("present", eeprom_present, 1);
    chk("ids lo", {device_id, vendor_id}, w(0));
    chk("ids hi", {subsys_device_id, subsys_vendor_id}, w(4));
    chk("options", option_bits, w(8));
    rd(8'h0C, q);
    chk("data after load", q, 0);
    rd(8'h10, q);
    chk("unmapped", q, 0);
    wr(8'h08, 32'h0000_FFFF, 4'h3);
    rd(8'h08, q);
    chk("cap read only", q, 32'h0000_0003);
    foreach (ra[i]) begin
      start(ra[i], 1'b0);
      if (i == 1) begin
        repeat (300) @(posedge clk);
        clk_en <= 1'b0;
        repeat (40) @(posedge clk);
        clk_en <= 1'b1;
      end
      wait_flag(1'b1, q);
      chk("aligned addr", q[22:16], {ra[i][6:2], 2'b00});
      rd(8'h0C, q);
      chk("read word", q, w({ra[i][6:2], 2'b00}));
    end
    wr(8'h0C, 32'hA5C3_0F1E, 4'hF);
    start(7'h20, 1'b1);
    wr(8'h0C, 32'h0, 4'hF);
    wait_flag(1'b0, q);
    {img[35], img[34], img[33], img[32]} = 32'hA5C3_0F1E;
    rd(8'h0C, q);
    chk("held data", q, 32'hA5C3_0F1E);
    start(7'h20, 1'b0);
    wait_flag(1'b1, q);
    rd(8'h0C, q);
    chk("written word", q, w(32));
    wr(8'h0C, 32'hFFFF_FFFF, 4'h2);
    rd(8'h0C, q);
    chk("lane write", q, w(32) | 32'h0000_FF00);
    tally_and_finish();
  end
endmodule // tb_ecl_config_loader
